// ==== hw/pcs_status_out.sv ====
module pcs_status_out
   import pcs_pkg::*;
#(
   parameter int PF_COUNT = 2,
   parameter int VF_COUNT = 6
) (
   input  wire logic                       MCLK,
   input  wire logic                       RESET_N,
   input  wire logic [PCS_ADDR_W-1:0]      REG_ADDR,
   input  wire logic [PCS_DATA_W-1:0]      REG_WDATA,
   input  wire logic                       REG_WR,
   input  wire logic                       REG_RD,
   output logic      [PCS_DATA_W-1:0]      REG_RDATA,
   input  wire logic [5:0]                 LTSSM_INDEX,
   input  wire logic                       BW_MGMT_EVT,
   input  wire logic                       AUTO_BW_EVT,
   input  wire logic                       EQ_REQ_EVT,
   output logic [PCS_LT_W-1:0]             LTSSM_STATE,
   output logic [PCS_PF_MAX-1:0]           RCB_STATUS,
   output logic                            LINK_STATUS_CHANGE_EVENT,
   output logic                            LINK_STATUS_CHANGE_EVENT_ALIAS,
   output logic [PCS_PF_MAX-1:0]           PF_HINT_REQUESTER_ENABLE_OUT,
   output logic [PCS_PF_MAX*PCS_ST_W-1:0]  PF_STEERING_TAG_MODE_OUT,
   output logic [PCS_VF_MAX-1:0]           VF_HINT_REQUESTER_ENABLE_OUT,
   output logic [PCS_VF_MAX*PCS_ST_W-1:0]  VF_STEERING_TAG_MODE_OUT
);

   localparam int PFM_W = PCS_PF_MAX * PCS_ST_W;
   localparam int VFM_W = PCS_VF_MAX * PCS_ST_W;

   // functions beyond the counts are reserved and held at zero
   localparam logic [PCS_PF_MAX-1:0] PF_MASK  = PCS_PF_MAX'((64'd1 << PF_COUNT) - 64'd1);
   localparam logic [PCS_VF_MAX-1:0] VF_MASK  = PCS_VF_MAX'((64'd1 << VF_COUNT) - 64'd1);
   localparam logic [PFM_W-1:0]      PFM_MASK = PFM_W'((64'd1 << (PCS_ST_W * PF_COUNT)) - 64'd1);
   localparam logic [VFM_W-1:0]      VFM_MASK = VFM_W'((64'd1 << (PCS_ST_W * VF_COUNT)) - 64'd1);

   // refuse counts that the output widths cannot carry
   if (PF_COUNT < 1 || PF_COUNT > PCS_PF_MAX) begin : g_pf_chk
      $error("PF_COUNT out of range");
   end
   if (VF_COUNT < 0 || VF_COUNT > PCS_VF_MAX) begin : g_vf_chk
      $error("VF_COUNT out of range");
   end

   // training engine index to reported code; unknown indices report quiet
   function automatic pcs_ltssm_type lt_map(input logic [5:0] idx);
      pcs_ltssm_type code;
      code = PCS_LT_DET_QUIET;
      case (idx)
         6'h00: code = PCS_LT_DET_QUIET;
         6'h01: code = PCS_LT_DET_ACTIVE;
         6'h02: code = PCS_LT_POL_ACTIVE;
         6'h03: code = PCS_LT_POL_COMPL;
         6'h04: code = PCS_LT_POL_CONFIG;
         6'h05: code = PCS_LT_CFG_LW_START;
         6'h06: code = PCS_LT_CFG_LW_ACC;
         6'h07: code = PCS_LT_CFG_LN_ACC;
         6'h08: code = PCS_LT_CFG_LN_WAIT;
         6'h09: code = PCS_LT_CFG_COMPLETE;
         6'h0A: code = PCS_LT_CFG_IDLE;
         6'h0B: code = PCS_LT_RCV_LOCK;
         6'h0C: code = PCS_LT_RCV_SPEED;
         6'h0D: code = PCS_LT_RCV_CFG;
         6'h0E: code = PCS_LT_RCV_IDLE;
         6'h0F: code = PCS_LT_L0;
         6'h10: code = PCS_LT_RX_L0S_ENT;
         6'h11: code = PCS_LT_RX_L0S_IDLE;
         6'h12: code = PCS_LT_RX_L0S_FTS;
         6'h13: code = PCS_LT_TX_L0S_ENT;
         6'h14: code = PCS_LT_TX_L0S_IDLE;
         6'h15: code = PCS_LT_TX_L0S_FTS;
         6'h16: code = PCS_LT_L1_ENTRY;
         6'h17: code = PCS_LT_L1_IDLE;
         6'h18: code = PCS_LT_L2_IDLE;
         6'h19: code = PCS_LT_L2_TX_WAKE;
         6'h1A: code = PCS_LT_DISABLED;
         6'h1B: code = PCS_LT_LBM_ENTRY;
         6'h1C: code = PCS_LT_LBM_ACTIVE;
         6'h1D: code = PCS_LT_LBM_EXIT;
         6'h1E: code = PCS_LT_LBS_ENTRY;
         6'h1F: code = PCS_LT_LBS_ACTIVE;
         6'h20: code = PCS_LT_LBS_EXIT;
         6'h21: code = PCS_LT_HOT_RESET;
         6'h22: code = PCS_LT_EQ_PH1;
         6'h23: code = PCS_LT_EQ_PH2;
         6'h24: code = PCS_LT_EQ_PH3;
         default: code = PCS_LT_DET_QUIET;
      endcase
      return code;
   endfunction

   // carriers
   pcs_bus_type bus;
   pcs_evt_type evt;

   // software state
   logic [PCS_CTRL_W-1:0] ctrl_r;
   logic [PCS_CTRL_W-1:0] ctrl_nxt;
   logic [PCS_PF_MAX-1:0] rcb_r;
   logic [PCS_PF_MAX-1:0] rcb_nxt;
   logic [PCS_PF_MAX-1:0] pf_en_r;
   logic [PCS_PF_MAX-1:0] pf_en_nxt;
   logic [PFM_W-1:0]      pf_mode_r;
   logic [PFM_W-1:0]      pf_mode_nxt;
   logic [PCS_VF_MAX-1:0] vf_en_r;
   logic [PCS_VF_MAX-1:0] vf_en_nxt;
   logic [VFM_W-1:0]      vf_mode_r;
   logic [VFM_W-1:0]      vf_mode_nxt;
   logic [PCS_STS_W-1:0]  sts_r;
   logic [PCS_STS_W-1:0]  sts_nxt;
   logic [PCS_DATA_W-1:0] rdata_nxt;

   // output-side next values
   pcs_ltssm_type         lt_nxt;
   logic [PCS_PF_MAX-1:0] rcb_out_nxt;
   logic                  chg_nxt;

   // address decode
   logic hit_ctrl;
   logic hit_rcb;
   logic hit_pf;
   logic hit_vf;
   logic hit_sts;
   logic hit_lt;
   logic rp_mode;
   logic [PCS_STS_W-1:0] evt_vec;
   logic [PCS_STS_W-1:0] ie_vec;
   logic [PCS_STS_W-1:0] sts_clr;

   assign bus.addr  = REG_ADDR;
   assign bus.wdata = REG_WDATA;
   assign bus.wr    = REG_WR;
   assign bus.rd    = REG_RD;
   assign evt.bw    = BW_MGMT_EVT;
   assign evt.ab    = AUTO_BW_EVT;
   assign evt.eq    = EQ_REQ_EVT;

   assign hit_ctrl = (bus.addr == PCS_OFS_CTRL);
   assign hit_rcb  = (bus.addr == PCS_OFS_RCB);
   assign hit_pf   = (bus.addr == PCS_OFS_PF_TPH);
   assign hit_vf   = (bus.addr == PCS_OFS_VF_TPH);
   assign hit_sts  = (bus.addr == PCS_OFS_LNK_STS);
   assign hit_lt   = (bus.addr == PCS_OFS_LTSSM);
   assign rp_mode  = ctrl_r[PCS_CTRL_RP_BIT];

   // configuration writes; bits beyond the function counts never stick
   assign ctrl_nxt    = (bus.wr && hit_ctrl) ? bus.wdata[PCS_CTRL_W-1:0] : ctrl_r;
   assign rcb_nxt     = (bus.wr && hit_rcb)  ? bus.wdata[PCS_PF_MAX-1:0] & PF_MASK : rcb_r;
   assign pf_en_nxt   = (bus.wr && hit_pf)
                        ? bus.wdata[PCS_TPH_EN_LSB +: PCS_PF_MAX] & PF_MASK : pf_en_r;
   assign pf_mode_nxt = (bus.wr && hit_pf)
                        ? bus.wdata[PCS_TPH_MODE_LSB +: PFM_W] & PFM_MASK : pf_mode_r;
   assign vf_en_nxt   = (bus.wr && hit_vf)
                        ? bus.wdata[PCS_TPH_EN_LSB +: PCS_VF_MAX] & VF_MASK : vf_en_r;
   assign vf_mode_nxt = (bus.wr && hit_vf)
                        ? bus.wdata[PCS_TPH_MODE_LSB +: VFM_W] & VFM_MASK : vf_mode_r;

   // link status: hardware set wins over a same-cycle software clear
   assign evt_vec = {evt.eq, evt.ab, evt.bw};
   assign ie_vec  = {ctrl_r[PCS_CTRL_EQ_IE_BIT], ctrl_r[PCS_CTRL_AB_IE_BIT],
                     ctrl_r[PCS_CTRL_BW_IE_BIT]};
   assign sts_clr = (bus.wr && hit_sts) ? bus.wdata[PCS_STS_W-1:0] : PCS_STS_RST;
   assign sts_nxt = (sts_r & ~sts_clr) | evt_vec;

   // event only in root port mode, and only for an enabled cause
   assign chg_nxt = rp_mode && ((evt_vec & ie_vec) != PCS_STS_RST);

   // boundary: endpoint per function, root port uses bit 0 only
   assign rcb_out_nxt = rp_mode ? {{(PCS_PF_MAX-1){1'b0}}, rcb_r[0]}
                                : rcb_r;

   assign lt_nxt = lt_map(LTSSM_INDEX);

   // read mux; unmapped addresses read as zero
   assign rdata_nxt = !bus.rd ? PCS_WORD_RST :
                      hit_ctrl ? PCS_DATA_W'(ctrl_r) :
                      hit_rcb  ? PCS_DATA_W'(rcb_r) :
                      hit_pf   ? PCS_DATA_W'({pf_mode_r, 4'h0, pf_en_r}) :
                      hit_vf   ? PCS_DATA_W'({vf_mode_r, vf_en_r}) :
                      hit_sts  ? PCS_DATA_W'(sts_r) :
                      hit_lt   ? PCS_DATA_W'(LTSSM_STATE) : PCS_WORD_RST;

   // software-visible registers
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         ctrl_r    <= PCS_CTRL_RST;
         rcb_r     <= '0;
         pf_en_r   <= '0;
         pf_mode_r <= '0;
         vf_en_r   <= '0;
         vf_mode_r <= '0;
         sts_r     <= PCS_STS_RST;
      end else begin
         ctrl_r    <= ctrl_nxt;
         rcb_r     <= rcb_nxt;
         pf_en_r   <= pf_en_nxt;
         pf_mode_r <= pf_mode_nxt;
         vf_en_r   <= vf_en_nxt;
         vf_mode_r <= vf_mode_nxt;
         sts_r     <= sts_nxt;
      end
   end

   // every output straight from a flop, quiet under reset
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         REG_RDATA                      <= PCS_WORD_RST;
         LTSSM_STATE                    <= PCS_LT_DET_QUIET;
         RCB_STATUS                     <= '0;
         LINK_STATUS_CHANGE_EVENT       <= 1'b0;
         LINK_STATUS_CHANGE_EVENT_ALIAS <= 1'b0;
         PF_HINT_REQUESTER_ENABLE_OUT   <= '0;
         PF_STEERING_TAG_MODE_OUT       <= '0;
         VF_HINT_REQUESTER_ENABLE_OUT   <= '0;
         VF_STEERING_TAG_MODE_OUT       <= '0;
      end else begin
         REG_RDATA                      <= rdata_nxt;
         LTSSM_STATE                    <= lt_nxt;
         RCB_STATUS                     <= rcb_out_nxt;
         LINK_STATUS_CHANGE_EVENT       <= chg_nxt;
         LINK_STATUS_CHANGE_EVENT_ALIAS <= chg_nxt;
         PF_HINT_REQUESTER_ENABLE_OUT   <= pf_en_r;
         PF_STEERING_TAG_MODE_OUT       <= pf_mode_r;
         VF_HINT_REQUESTER_ENABLE_OUT   <= vf_en_r;
         VF_STEERING_TAG_MODE_OUT       <= vf_mode_r;
      end
   end

   // checks on what this block drives
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   AST_RESET_QUIET: assert property (disable iff (1'b0) !RESET_N |=>
      LTSSM_STATE == PCS_LT_DET_QUIET && !LINK_STATUS_CHANGE_EVENT && RCB_STATUS == '0)
      else $error("outputs not quiet after reset");

   AST_LT_DETECT: assert property (LTSSM_INDEX == 6'h01 |=> LTSSM_STATE == 6'h01)
      else $error("detect active code wrong");

   AST_LT_POLL: assert property (LTSSM_INDEX == 6'h04 |=> LTSSM_STATE == 6'h04)
      else $error("polling configuration code wrong");

   AST_LT_CFG: assert property (LTSSM_INDEX == 6'h0A |=> LTSSM_STATE == 6'h0A)
      else $error("configuration idle code wrong");

   AST_LT_RCV: assert property (LTSSM_INDEX == 6'h0D |=> LTSSM_STATE == 6'h0D)
      else $error("recovery receiver config code wrong");

   AST_LT_L0: assert property (LTSSM_INDEX == 6'h0F |=> LTSSM_STATE == 6'h10)
      else $error("L0 code wrong");

   AST_LT_L2: assert property (LTSSM_INDEX == 6'h19 |=> LTSSM_STATE == 6'h1A)
      else $error("L2 transmit wake code wrong");

   AST_LT_LOOP: assert property (LTSSM_INDEX == 6'h20 |=> LTSSM_STATE == 6'h26)
      else $error("slave loopback exit code wrong");

   AST_LT_EQ: assert property (LTSSM_INDEX == 6'h23 |=> LTSSM_STATE == 6'h2A)
      else $error("equalization phase two code wrong");

   AST_RCB_EP: assert property (!rp_mode ##1 !rp_mode |->
      RCB_STATUS == $past(rcb_r))
      else $error("endpoint boundary not per function");

   AST_RCB_RP: assert property (rp_mode |=> RCB_STATUS[PCS_PF_MAX-1:1] == '0)
      else $error("root port boundary reserved bits set");

   AST_EVT_BW: assert property (rp_mode && ctrl_r[PCS_CTRL_BW_IE_BIT] && evt.bw |=>
      LINK_STATUS_CHANGE_EVENT && sts_r[PCS_STS_BW_BIT])
      else $error("bandwidth change not flagged");

   AST_EVT_AB: assert property (rp_mode && ctrl_r[PCS_CTRL_AB_IE_BIT] && evt.ab |=>
      LINK_STATUS_CHANGE_EVENT && sts_r[PCS_STS_AB_BIT])
      else $error("autonomous change not flagged");

   AST_EVT_EQ: assert property (evt.eq |=> sts_r[PCS_STS_EQ_BIT])
      else $error("equalization request lost");

   AST_EVT_MASK: assert property (ie_vec == 3'h0 |=> !LINK_STATUS_CHANGE_EVENT)
      else $error("event raised with causes disabled");

   AST_EP_SILENT: assert property (!rp_mode |=> !LINK_STATUS_CHANGE_EVENT)
      else $error("event raised in endpoint mode");

   AST_PF_TPH: assert property (bus.wr && hit_pf |=> ##1
      PF_HINT_REQUESTER_ENABLE_OUT == ($past(bus.wdata[3:0], 2) & PF_MASK) &&
      PF_STEERING_TAG_MODE_OUT[PFM_W-1:PCS_ST_W*PF_COUNT] == '0)
      else $error("function hint outputs wrong");

   AST_VF_TPH: assert property (bus.wr && hit_vf |=> ##1
      VF_HINT_REQUESTER_ENABLE_OUT == ($past(bus.wdata[7:0], 2) & VF_MASK) &&
      VF_STEERING_TAG_MODE_OUT[VFM_W-1:PCS_ST_W*VF_COUNT] == '0)
      else $error("virtual function hint outputs wrong");

   // status bits must survive until software clears them, in any mode
   AST_STS_SET: assert property (evt_vec != PCS_STS_RST |=>
      (sts_r & $past(evt_vec)) == $past(evt_vec))
      else $error("status cause not latched");

   AST_STS_HOLD: assert property (!(bus.wr && hit_sts) |=>
      (sts_r & $past(sts_r)) == $past(sts_r))
      else $error("status bit lost without a clear");

   AST_EVT_EQ_OUT: assert property (rp_mode && ctrl_r[PCS_CTRL_EQ_IE_BIT] && evt.eq |=>
      LINK_STATUS_CHANGE_EVENT)
      else $error("equalization request not flagged");

   AST_ALIAS_SAME: assert property (
      LINK_STATUS_CHANGE_EVENT_ALIAS == LINK_STATUS_CHANGE_EVENT)
      else $error("event copies differ");

   AST_RCB_RP_BIT0: assert property (rp_mode |=>
      RCB_STATUS[0] == $past(rcb_r[0]))
      else $error("root port boundary bit wrong");

   AST_LT_L1: assert property (LTSSM_INDEX == 6'h16 |=> LTSSM_STATE == 6'h17)
      else $error("L1 entry code wrong");

   AST_LT_HOT: assert property (LTSSM_INDEX == 6'h21 |=> LTSSM_STATE == 6'h27)
      else $error("hot reset code wrong");

   AST_LT_UNLISTED: assert property (LTSSM_INDEX > 6'h24 |=> LTSSM_STATE == 6'h00)
      else $error("unlisted index not reported as quiet");

   COV_RP_BW:  cover property (rp_mode && evt.bw ##1 LINK_STATUS_CHANGE_EVENT);
   COV_EQ_CLR: cover property (evt.eq && bus.wr && hit_sts && bus.wdata[PCS_STS_EQ_BIT]);
   COV_L0:     cover property (LTSSM_STATE == PCS_LT_L0);
   COV_LOOP:   cover property (LTSSM_STATE == PCS_LT_LBS_ACTIVE);

endmodule

// ==== hw/pcs_pkg.sv ====
package pcs_pkg;

   // register bus geometry
   localparam int PCS_ADDR_W = 8;
   localparam int PCS_DATA_W = 32;

   // register offsets (byte addresses, one aligned word each)
   localparam logic [7:0] PCS_OFS_CTRL    = 8'h00;
   localparam logic [7:0] PCS_OFS_RCB     = 8'h04;
   localparam logic [7:0] PCS_OFS_PF_TPH  = 8'h08;
   localparam logic [7:0] PCS_OFS_VF_TPH  = 8'h0C;
   localparam logic [7:0] PCS_OFS_LNK_STS = 8'h10;
   localparam logic [7:0] PCS_OFS_LTSSM   = 8'h14;

   // control register fields
   localparam int PCS_CTRL_W         = 4;
   localparam int PCS_CTRL_RP_BIT    = 0;
   localparam int PCS_CTRL_BW_IE_BIT = 1;
   localparam int PCS_CTRL_AB_IE_BIT = 2;
   localparam int PCS_CTRL_EQ_IE_BIT = 3;

   // hint register fields
   localparam int PCS_TPH_EN_LSB   = 0;
   localparam int PCS_TPH_MODE_LSB = 8;

   // link status fields (write one to clear)
   localparam int PCS_STS_W      = 3;
   localparam int PCS_STS_BW_BIT = 0;
   localparam int PCS_STS_AB_BIT = 1;
   localparam int PCS_STS_EQ_BIT = 2;

   // output widths
   localparam int PCS_PF_MAX = 4;
   localparam int PCS_VF_MAX = 8;
   localparam int PCS_ST_W   = 3;
   localparam int PCS_LT_W   = 6;

   // reset values
   localparam logic [PCS_CTRL_W-1:0] PCS_CTRL_RST = 4'h0;
   localparam logic [PCS_STS_W-1:0]  PCS_STS_RST  = 3'h0;
   localparam logic [31:0]           PCS_WORD_RST = 32'h0000_0000;

   // reported training state codes
   typedef enum logic [5:0] {
      PCS_LT_DET_QUIET   = 6'h00, PCS_LT_DET_ACTIVE  = 6'h01,
      PCS_LT_POL_ACTIVE  = 6'h02, PCS_LT_POL_COMPL   = 6'h03,
      PCS_LT_POL_CONFIG  = 6'h04, PCS_LT_CFG_LW_START = 6'h05,
      PCS_LT_CFG_LW_ACC  = 6'h06, PCS_LT_CFG_LN_ACC  = 6'h07,
      PCS_LT_CFG_LN_WAIT = 6'h08, PCS_LT_CFG_COMPLETE = 6'h09,
      PCS_LT_CFG_IDLE    = 6'h0A, PCS_LT_RCV_LOCK    = 6'h0B,
      PCS_LT_RCV_SPEED   = 6'h0C, PCS_LT_RCV_CFG     = 6'h0D,
      PCS_LT_RCV_IDLE    = 6'h0E, PCS_LT_L0          = 6'h10,
      PCS_LT_RX_L0S_ENT  = 6'h11, PCS_LT_RX_L0S_IDLE = 6'h12,
      PCS_LT_RX_L0S_FTS  = 6'h13, PCS_LT_TX_L0S_ENT  = 6'h14,
      PCS_LT_TX_L0S_IDLE = 6'h15, PCS_LT_TX_L0S_FTS  = 6'h16,
      PCS_LT_L1_ENTRY    = 6'h17, PCS_LT_L1_IDLE     = 6'h18,
      PCS_LT_L2_IDLE     = 6'h19, PCS_LT_L2_TX_WAKE  = 6'h1A,
      PCS_LT_DISABLED    = 6'h20, PCS_LT_LBM_ENTRY   = 6'h21,
      PCS_LT_LBM_ACTIVE  = 6'h22, PCS_LT_LBM_EXIT    = 6'h23,
      PCS_LT_LBS_ENTRY   = 6'h24, PCS_LT_LBS_ACTIVE  = 6'h25,
      PCS_LT_LBS_EXIT    = 6'h26, PCS_LT_HOT_RESET   = 6'h27,
      PCS_LT_EQ_PH1      = 6'h28, PCS_LT_EQ_PH2      = 6'h2A,
      PCS_LT_EQ_PH3      = 6'h2B
   } pcs_ltssm_type;

   // one register bus request
   typedef struct packed {
      logic [PCS_ADDR_W-1:0] addr;
      logic [PCS_DATA_W-1:0] wdata;
      logic                  wr;
      logic                  rd;
   } pcs_bus_type;

   // link training events, one bit per cause, ordered as the status fields
   typedef struct packed {
      logic eq;
      logic ab;
      logic bw;
   } pcs_evt_type;

endpackage

// ==== tb/pcs_user_model.sv ====
module pcs_user_model
   import pcs_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  rp_mode,
   input  wire logic                  evt,
   input  wire logic [PCS_PF_MAX-1:0] rcb_raw,
   output logic      [15:0]           evt_count,
   output logic      [PCS_PF_MAX-1:0] rcb_view
);
   timeunit 1ns;
   timeprecision 1ps;

   // root port keeps only bit 0; user logic must not lean on reserved bits
   assign rcb_view = rp_mode ? {3'h0, rcb_raw[0]} : rcb_raw;

   // every high cycle counts as its own event, so no edge detect here
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         evt_count <= 16'h0000;
      end else if (evt) begin
         evt_count <= evt_count + 16'h0001;
      end
   end
endmodule

// ==== tb/pcs_status_out_tb.sv ====
module pcs_status_out_tb
   import pcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int PF_N = 2;
   localparam int VF_N = 6;
   localparam logic [3:0]  PF_EN_M = 4'((1 << PF_N) - 1);
   localparam logic [11:0] PF_ST_M = 12'((1 << (3 * PF_N)) - 1);
   localparam logic [7:0]  VF_EN_M = 8'((1 << VF_N) - 1);
   localparam logic [23:0] VF_ST_M = 24'((1 << (3 * VF_N)) - 1);

   logic        MCLK;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] rdata;
   logic [5:0]  lt_idx;
   logic [2:0]  ev;
   logic [5:0]  lt_out;
   logic [3:0]  rcb;
   logic        lsc;
   logic        lsc_alias;
   logic [3:0]  pf_en;
   logic [11:0] pf_st;
   logic [7:0]  vf_en;
   logic [23:0] vf_st;
   logic [15:0] evt_count;
   logic [3:0]  rcb_view;
   logic [3:0]  ctrl_v;
   logic [31:0] d;
   logic        hit;
   int          num_errors;
   int          compares;
   int          exp_cnt;
   int          cycles;
   int unsigned seed_v;

   pcs_status_out #(.PF_COUNT(PF_N), .VF_COUNT(VF_N)) u_pcs_status_out (
      .MCLK(MCLK), .RESET_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .LTSSM_INDEX(lt_idx),
      .BW_MGMT_EVT(ev[0]), .AUTO_BW_EVT(ev[1]), .EQ_REQ_EVT(ev[2]),
      .LTSSM_STATE(lt_out), .RCB_STATUS(rcb), .LINK_STATUS_CHANGE_EVENT(lsc),
      .LINK_STATUS_CHANGE_EVENT_ALIAS(lsc_alias), .PF_HINT_REQUESTER_ENABLE_OUT(pf_en),
      .PF_STEERING_TAG_MODE_OUT(pf_st), .VF_HINT_REQUESTER_ENABLE_OUT(vf_en),
      .VF_STEERING_TAG_MODE_OUT(vf_st));

   pcs_user_model u_pcs_user_model (
      .clk(MCLK), .rst_n(rst_n), .rp_mode(ctrl_v[0]), .evt(lsc),
      .rcb_raw(rcb), .evt_count(evt_count), .rcb_view(rcb_view));

   // clock generator, 5 ns period
   initial begin
      MCLK = 1'b0;
      forever #2.5 MCLK = ~MCLK;
   end

   // reported code for each engine index
   function automatic logic [5:0] exp_lt(input logic [5:0] i);
      if (i <= 6'h0E) return i;
      if (i <= 6'h19) return i + 6'h01;
      if (i <= 6'h22) return i + 6'h06;
      if (i <= 6'h24) return i + 6'h07;
      return 6'h00;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge MCLK);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge MCLK);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge MCLK);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge MCLK);
      reg_rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic close_out();
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hang guard, well above the fewer than a thousand cycles the tests need
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      lt_idx = 6'h0F;
      ev = 3'h7;
      ctrl_v = 4'h0;
      seed_v = $urandom(53250);
      // a live index and events during reset must not show
      // reset sampled low at four edges, lifted just after the fourth
      repeat (3) @(posedge MCLK);
      #1;
      chk({26'h0, lt_out}, 32'h0);
      chk({14'h0, rcb, pf_en, vf_en, lsc, lsc_alias}, 32'h0);
      chk({8'h0, vf_st} | {20'h0, pf_st}, 32'h0);
      @(posedge MCLK);
      rst_n <= 1'b1;
      ev <= 3'h0;
      $display("test reset done");

      // every index, listed or not, on the output and in the register
      for (int i = 0; i < 64; i++) begin
         @(posedge MCLK);
         lt_idx <= 6'(i);
         @(posedge MCLK);
         #1;
         chk({26'h0, lt_out}, {26'h0, exp_lt(6'(i))});
         rd_chk(PCS_OFS_LTSSM, {26'h0, exp_lt(6'(i))});
      end
      $display("test ltssm done");

      // hint fields and boundary bits, all-ones first to hit reserved bits (the VF hint gets ~d, so all-zeros first)
      for (int k = 0; k < 10; k++) begin
         d = (k == 0) ? 32'hFFFF_FFFF : $urandom();
         ctrl_v = {3'h0, k[0]};
         wr(PCS_OFS_CTRL, {28'h0, ctrl_v});
         wr(PCS_OFS_RCB, d);
         wr(PCS_OFS_PF_TPH, d);
         wr(PCS_OFS_VF_TPH, ~d);
         @(posedge MCLK);
         #1;
         if (ctrl_v[0]) begin
            chk({31'h0, rcb_view[0]}, {31'h0, d[0]});
            chk({28'h0, rcb}, {31'h0, d[0]});
         end else begin
            chk({28'h0, rcb}, {28'h0, d[3:0] & PF_EN_M});
         end
         chk({28'h0, pf_en}, {28'h0, d[3:0] & PF_EN_M});
         chk({20'h0, pf_st}, {20'h0, d[19:8] & PF_ST_M});
         chk({24'h0, vf_en}, {24'h0, ~d[7:0] & VF_EN_M});
         chk({8'h0, vf_st}, {8'h0, ~d[31:8] & VF_ST_M});
         rd_chk(PCS_OFS_PF_TPH, {12'h0, d[19:8] & PF_ST_M, 4'h0, d[3:0] & PF_EN_M});
      end
      $display("test hint done");

      // each cause under every mode and enable setting
      exp_cnt = 0;
      for (int m = 0; m < 16; m++) begin
         ctrl_v = 4'(m);
         wr(PCS_OFS_CTRL, {28'h0, ctrl_v});
         for (int c = 0; c < 3; c++) begin
            @(posedge MCLK);
            ev <= 3'(1 << c);
            @(posedge MCLK);
            ev <= 3'h0;
            #1;
            hit = ctrl_v[0] && ctrl_v[c + 1];
            exp_cnt += int'(hit);
            chk({30'h0, lsc, lsc_alias}, {30'h0, hit, hit});
            @(posedge MCLK);
            #1;
            chk({31'h0, lsc}, 32'h0);
            rd_chk(PCS_OFS_LNK_STS, 32'(1 << c));
            wr(PCS_OFS_LNK_STS, 32'h0000_0007);
            rd_chk(PCS_OFS_LNK_STS, 32'h0000_0000);
         end
      end
      // a cause landing on its own clear stays set
      @(posedge MCLK);
      ev <= 3'h4;
      reg_wr <= 1'b1;
      reg_addr <= PCS_OFS_LNK_STS;
      reg_wdata <= 32'h0000_0007;
      @(posedge MCLK);
      ev <= 3'h0;
      reg_wr <= 1'b0;
      exp_cnt += int'(ctrl_v[0] && ctrl_v[3]);
      rd_chk(PCS_OFS_LNK_STS, 32'h0000_0004);
      $display("test events done");

      // random bursts: one pulse per busy cycle, shared causes merge
      for (int n = 0; n < 40; n++) begin
         @(posedge MCLK);
         ev <= 3'($urandom());
         #1;
         exp_cnt += int'(ctrl_v[0] && ((ev & ctrl_v[3:1]) != 3'h0));
      end
      @(posedge MCLK);
      ev <= 3'h0;
      repeat (3) @(posedge MCLK);
      #1;
      chk({16'h0, evt_count}, 32'(exp_cnt));
      // unmapped place neither stores nor disturbs
      wr(8'h3C, $urandom());
      rd_chk(8'h3C, 32'h0000_0000);
      rd_chk(PCS_OFS_CTRL, {28'h0, ctrl_v});
      $display("test bursts done");

      // a second reset mid-run clears outputs and written state
      @(posedge MCLK);
      rst_n <= 1'b0;
      lt_idx <= 6'h10;
      repeat (2) @(posedge MCLK);
      #1;
      chk({26'h0, lt_out}, 32'h0);
      chk({10'h0, pf_st, pf_en, rcb, lsc, lsc_alias}, 32'h0);
      chk({vf_st, vf_en}, 32'h0);
      @(posedge MCLK);
      rst_n <= 1'b1;
      ctrl_v = 4'h0;
      rd_chk(PCS_OFS_CTRL, 32'h0000_0000);
      $display("test reset again done");
      close_out();
   end
endmodule
